// [design/tps_top.sv]
`timescale 1ns/1ps
// What this block does
// - On door close, wake or tray install with empty path, home the roller.
// - A pickup command first energizes the pickup solenoid.
// - After the solenoid, the feed clutch engages to draw a sheet.
// - At the between-page position the clutch releases and feeding continues.
// - Controller sends feed-stop; device stops the motor and goes standby.
// - No leading edge after 1 s: stop motor once, restart, refire at 0.7 s.
// - No leading edge within 3 s: halt and report a pickup delay jam.
// - Media seen at power-up, wake or cover close is a residual jam.
// - Solenoid and clutch move only after a controller pickup command; the motor also runs for homing.
// - Any jam stops the feed and notifies the controller.
module tps_top
    import tps_pkg::*;
#(
    parameter int unsigned P_RETRY_CYC  = RETRY_CYC,
    parameter int unsigned P_REFIRE_CYC = REFIRE_CYC,
    parameter int unsigned P_DELAY_CYC  = DELAY_JAM_CYC
)
(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_pickup_cmd,
    input  wire logic       i_feed_stop_cmd,
    input  wire logic       i_door_closed,
    input  wire logic       i_wake,
    input  wire logic       i_tray_installed,
    input  wire logic       i_path_sensor,
    input  wire logic       i_roller_home,
    input  wire logic       i_between_page,
    output logic            o_pickup_solenoid,
    output logic            o_feed_clutch,
    output logic            o_feed_motor,
    output logic            o_jam,
    output logic [1:0]      o_jam_code,
    output logic            o_jam_notify,
    output logic            o_busy
);
    logic       rst_meta_q;
    logic       rst_n;
    tps_state_t state_q;
    tps_state_t state_d;
    logic       home_pend_q;
    logic       seen_q;
    logic       retried_q;
    logic       pick_start;
    logic       active;
    logic       no_edge;
    logic       home_evt;
    logic [1:0] jam_code_d;

    tps_tmr_if #(.W(TMR_W)) tmain ();
    tps_tmr_if #(.W(TMR_W)) trefire ();

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    tps_timer u_tmain (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .tif     (tmain)
    );

    tps_timer u_trefire (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .tif     (trefire)
    );

    assign home_evt   = i_door_closed | i_wake | i_tray_installed;
    assign active     = (state_q == ST_SOL) || (state_q == ST_FEED) ||
                        (state_q == ST_RSTOP) || (state_q == ST_RWAIT);
    assign no_edge    = !seen_q && !i_path_sensor;
    assign pick_start = (state_q == ST_IDLE) && !home_pend_q &&
                        i_pickup_cmd;

    // Main pickup timer runs from solenoid on until the leading edge; refire timer runs only in ST_RWAIT
    assign tmain.run   = active && !seen_q;
    assign tmain.clr   = pick_start || (active && i_path_sensor);
    assign trefire.run = (state_q == ST_RWAIT);
    assign trefire.clr = (state_q == ST_RSTOP);

    // Sequencer next state; outside ST_IDLE feed-stop outranks everything, delay-jam detection included
    always_comb
    begin
        state_d    = state_q;
        jam_code_d = o_jam_code;
        case (state_q)
            ST_IDLE:
            begin
                if (home_pend_q)
                begin
                    if (i_path_sensor)
                    begin
                        state_d    = ST_JAM;
                        jam_code_d = JAM_RESIDUAL;
                    end
                    else
                        state_d = ST_HOME;
                end
                else if (i_pickup_cmd)
                    state_d = ST_SOL;
            end
            ST_HOME:
                if (i_roller_home || i_feed_stop_cmd)
                    state_d = ST_IDLE;
            ST_SOL:
                state_d = i_feed_stop_cmd ? ST_IDLE : ST_FEED;
            ST_FEED:
            begin
                if (i_feed_stop_cmd)
                    state_d = ST_IDLE;
                else if (no_edge && tmain.elapsed >= P_DELAY_CYC)
                begin
                    state_d    = ST_JAM;
                    jam_code_d = JAM_DELAY;
                end
                else if (no_edge && !retried_q &&
                         tmain.elapsed >= P_RETRY_CYC)
                    state_d = ST_RSTOP;
                else if (seen_q && i_between_page)
                    state_d = ST_ADV;
            end
            ST_RSTOP:
                state_d = i_feed_stop_cmd ? ST_IDLE : ST_RWAIT;
            ST_RWAIT:
            begin
                if (i_feed_stop_cmd)
                    state_d = ST_IDLE;
                else if (no_edge && tmain.elapsed >= P_DELAY_CYC)
                begin
                    state_d    = ST_JAM;
                    jam_code_d = JAM_DELAY;
                end
                else if (trefire.elapsed >= P_REFIRE_CYC)
                    state_d = ST_SOL;
            end
            ST_ADV:
                if (i_feed_stop_cmd)
                    state_d = ST_IDLE;
            ST_JAM:
                if (i_feed_stop_cmd)
                begin
                    state_d    = ST_IDLE;           // Controller clears
                    jam_code_d = JAM_NONE;
                end
            default:
                state_d = ST_IDLE;
        endcase
    end

    // State and drive outputs, all registered from the next state
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q           <= ST_IDLE;
            o_pickup_solenoid <= 1'b0;
            o_feed_clutch     <= 1'b0;
            o_feed_motor      <= 1'b0;
            o_jam             <= 1'b0;
            o_jam_code        <= JAM_NONE;
            o_jam_notify      <= 1'b0;
            o_busy            <= 1'b0;
        end
        else
        begin
            state_q           <= state_d;
            o_pickup_solenoid <= (state_d == ST_SOL) ||
                                 ((state_d == ST_FEED) && !seen_q);
            o_feed_clutch     <= (state_d == ST_FEED);
            o_feed_motor      <= (state_d == ST_HOME) ||
                                 (state_d == ST_SOL) ||
                                 (state_d == ST_FEED) ||
                                 (state_d == ST_RWAIT) ||
                                 (state_d == ST_ADV);
            o_jam             <= (state_d == ST_JAM);
            o_jam_code        <= jam_code_d;
            o_jam_notify      <= (state_d == ST_JAM) && (state_q != ST_JAM);
            o_busy            <= (state_d != ST_IDLE);
        end
    end

    // Homing request; power-up counts as one, and a new event wins a clear
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
            home_pend_q <= 1'b1;
        else if (home_evt)
            home_pend_q <= 1'b1;
        else if (state_q == ST_IDLE)
            home_pend_q <= 1'b0;
    end

    // Leading-edge seen and single-retry bookkeeping per sheet
    always_ff @(posedge i_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seen_q    <= 1'b0;
            retried_q <= 1'b0;
        end
        else if (pick_start)
        begin
            seen_q    <= 1'b0;
            retried_q <= 1'b0;
        end
        else
        begin
            if (active && i_path_sensor)
                seen_q <= 1'b1;
            if (state_q == ST_RSTOP)
                retried_q <= 1'b1;                  // Only one retry
        end
    end

    home_go_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_IDLE && home_pend_q && !i_path_sensor)
        |=> (state_q == ST_HOME && o_feed_motor && !o_pickup_solenoid))
        else $error("homing did not start");

    pick_sol_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        pick_start ##1 !i_feed_stop_cmd
        |-> (o_pickup_solenoid && !o_feed_clutch)
        ##1 (o_pickup_solenoid && o_feed_clutch))
        else $error("pickup did not energize solenoid first");

    clutch_ord_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        $rose(o_feed_clutch) |-> $past(o_pickup_solenoid))
        else $error("clutch engaged before solenoid");

    bp_release_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_FEED && seen_q && i_between_page && !i_feed_stop_cmd)
        |=> (!o_feed_clutch && o_feed_motor))
        else $error("clutch not released at between-page position");

    stop_feed_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (i_feed_stop_cmd && state_q != ST_JAM && state_q != ST_IDLE)
        |=> (!o_feed_motor && !o_busy))
        else $error("feed-stop did not stop motor");

    retry_seq_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_FEED && no_edge && !retried_q && !i_feed_stop_cmd &&
         tmain.elapsed >= P_RETRY_CYC && tmain.elapsed < P_DELAY_CYC)
        ##1 !i_feed_stop_cmd
        |-> !o_feed_motor ##1 (o_feed_motor && !o_pickup_solenoid))
        else $error("pickup retry sequence wrong");

    delay_jam_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        ((state_q == ST_FEED || state_q == ST_RWAIT) && no_edge &&
         !i_feed_stop_cmd && tmain.elapsed >= P_DELAY_CYC)
        |=> (o_jam && o_jam_code == JAM_DELAY && o_jam_notify))
        else $error("pickup delay jam not reported");

    resid_jam_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (state_q == ST_IDLE && home_pend_q && i_path_sensor)
        |=> (o_jam && o_jam_code == JAM_RESIDUAL))
        else $error("residual jam not reported");

    jam_stop_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        o_jam |-> (!o_feed_motor && !o_feed_clutch && !o_pickup_solenoid))
        else $error("drives active during jam");

    edge_clr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
        (active && i_path_sensor) |=> (tmain.elapsed == TMR_ZERO))
        else $error("timer not cleared on leading edge");
endmodule // tps_top

// [include/tps_pkg.sv]
package tps_pkg;
    // Pickup timing, in milliseconds as specified
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned RETRY_MS      = 1000;
    localparam int unsigned REFIRE_MS     = 700;
    localparam int unsigned DELAY_JAM_MS  = 3000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned RETRY_CYC     = RETRY_MS * CYC_PER_MS;
    localparam int unsigned REFIRE_CYC    = REFIRE_MS * CYC_PER_MS;
    localparam int unsigned DELAY_JAM_CYC = DELAY_JAM_MS * CYC_PER_MS;
    localparam int unsigned TMR_W         = 32;

    // Jam codes reported to the engine controller
    localparam logic [1:0] JAM_NONE     = 2'h0;
    localparam logic [1:0] JAM_DELAY    = 2'h1;
    localparam logic [1:0] JAM_RESIDUAL = 2'h2;

    localparam logic [TMR_W-1:0] TMR_ZERO = 32'h00000000;
    localparam logic [TMR_W-1:0] TMR_ONE  = 32'h00000001;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_HOME   = 8'h02,
        ST_SOL    = 8'h04,
        ST_FEED   = 8'h08,
        ST_RSTOP  = 8'h10,
        ST_RWAIT  = 8'h20,
        ST_ADV    = 8'h40,
        ST_JAM    = 8'h80
    } tps_state_t;
endpackage

// [include/tps_tmr_if.sv]
`timescale 1ns/1ps
interface tps_tmr_if #(parameter int unsigned W = 32);
    logic         run;
    logic         clr;
    logic [W-1:0] elapsed;
    modport ctl (output run, output clr, input elapsed);
    modport cnt (input run, input clr, output elapsed);
endinterface

// [design/tps_timer.sv]
`timescale 1ns/1ps
module tps_timer
    import tps_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    tps_tmr_if.cnt    tif
);
    // Elapsed counter; clear wins so a restart never sees stale time
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            tif.elapsed <= TMR_ZERO;
        else if (tif.clr)
            tif.elapsed <= TMR_ZERO;
        else if (tif.run && (tif.elapsed != '1))
            tif.elapsed <= tif.elapsed + TMR_ONE; // Saturates, never wraps
    end
endmodule // tps_timer

// [dv/tps_engine_model.sv]
`timescale 1ns/1ps
// Engine controller stand-in: issues command pulses, counts jam reports
module tps_engine_model
(
    input  wire logic i_clk,
    input  wire logic i_jam_notify,
    output logic      o_pickup_cmd,
    output logic      o_feed_stop_cmd,
    output int        o_notify_cnt
);
    // Idle link: no command outstanding at time zero
    initial
    begin
        o_pickup_cmd    = 1'h0;
        o_feed_stop_cmd = 1'h0;
        o_notify_cnt    = 0;
    end

    // A stuck notify would be counted many times, so a count exposes it
    always @(posedge i_clk)
    begin
        if (i_jam_notify === 1'h1)
            o_notify_cnt <= o_notify_cnt + 1;
    end

    // Pickup: one-cycle pulse launched just after an edge
    task automatic send_pickup();
        @(posedge i_clk);
        o_pickup_cmd <= 1'h1;
        @(posedge i_clk);
        o_pickup_cmd <= 1'h0;
    endtask

    // Feed-stop ends a feed and also clears a reported jam
    task automatic send_stop();
        @(posedge i_clk);
        o_feed_stop_cmd <= 1'h1;
        @(posedge i_clk);
        o_feed_stop_cmd <= 1'h0;
    endtask
endmodule // tps_engine_model

// [dv/tray_pickup_sequencer_bench.sv]
`timescale 1ns/1ps
module tray_pickup_sequencer_bench;
    import tps_pkg::*;
    localparam int unsigned RC = 40;
    localparam int unsigned FC = 20;
    localparam int unsigned DC = 120;
    logic       clk, rstn, door, wake, tray, sens, home, btw;
    logic       pick, stop, sol, clu, mot, jam, ntf, busy;
    logic [1:0] code;
    int         notes;
    int         n, n1, n2;
    int         err_total  = 0;
    int         num_checks = 0;
    wire  [4:0] drv = {busy, jam, sol, clu, mot};

    tps_top #(.P_RETRY_CYC(RC), .P_REFIRE_CYC(FC), .P_DELAY_CYC(DC)) dut_u
    (
        .i_clk(clk), .i_rstn(rstn), .i_pickup_cmd(pick),
        .i_feed_stop_cmd(stop), .i_door_closed(door), .i_wake(wake),
        .i_tray_installed(tray), .i_path_sensor(sens),
        .i_roller_home(home), .i_between_page(btw),
        .o_pickup_solenoid(sol), .o_feed_clutch(clu), .o_feed_motor(mot),
        .o_jam(jam), .o_jam_code(code), .o_jam_notify(ntf), .o_busy(busy)
    );

    tps_engine_model eng_u
    (
        .i_clk(clk), .i_jam_notify(ntf), .o_pickup_cmd(pick),
        .o_feed_stop_cmd(stop), .o_notify_cnt(notes)
    );

    // Free-running 100 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Bounded wait at falling edges, where outputs have settled
    task automatic wait_bit(input int idx, input logic v, output int cnt);
        cnt = 0;
        while (drv[idx] !== v && cnt < 500)
        begin
            @(negedge clk);
            cnt++;
        end
        chk("awaited level", drv[idx], v);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Power-up first, then each homing event, each ended at roller home
    task automatic t_home();
        for (int k = 3; k >= 0; k--)
        begin
            @(posedge clk);
            door <= (k == 0);
            wake <= (k == 1);
            tray <= (k == 2);
            @(posedge clk);
            {door, wake, tray} <= 3'h0;
            wait_bit(0, 1'h1, n);
            chk("homing drives", {jam, sol, clu, mot}, 4'h1);
            @(posedge clk);
            home <= 1'h1;
            wait_bit(4, 1'h0, n);
            chk("homed motor", mot, 1'h0);
            @(posedge clk);
            home <= 1'h0;
        end
    endtask

    // Clean pickup; leading edge seen early must cancel both timeouts
    task automatic t_feed();
        eng_u.send_pickup();
        wait_bit(2, 1'h1, n);
        chk("solenoid first", {sol, clu, mot}, 3'h5);
        @(negedge clk);
        chk("clutch engaged", clu, 1'h1);
        @(posedge clk);
        sens <= 1'h1;
        wait_bit(2, 1'h0, n);
        repeat (DC + 10) @(negedge clk);
        chk("no jam after edge", {jam, mot}, 2'h1);
        @(posedge clk);
        btw <= 1'h1;
        wait_bit(1, 1'h0, n);
        chk("motor keeps feeding", mot, 1'h1);
        eng_u.send_stop();
        wait_bit(0, 1'h0, n);
        chk("standby", busy, 1'h0);
        @(posedge clk);
        {sens, btw} <= 2'h0;
    endtask

    // No leading edge: one retry, then a delay jam timed from first fire
    task automatic t_retry_jam();
        eng_u.send_pickup();
        wait_bit(2, 1'h1, n);
        wait_bit(0, 1'h0, n1);
        chk("retry time", (n1 + 2 >= RC) && (n1 <= RC + 2), 1'h1);
        chk("retry stop", {sol, clu, mot}, 3'h0);
        @(negedge clk);
        chk("restart", {sol, mot}, 2'h1);
        wait_bit(2, 1'h1, n2);
        chk("refire time", (n2 + 2 >= FC) && (n2 <= FC + 2), 1'h1);
        wait_bit(3, 1'h1, n);
        n = n + n1 + n2 + 1;
        chk("jam time", (n + 3 >= DC) && (n <= DC + 3), 1'h1);
        chk("jam code", code, JAM_DELAY);
        chk("jam halts", {ntf, sol, clu, mot}, 4'h8);
        eng_u.send_stop();
        wait_bit(3, 1'h0, n);
        chk("jam cleared", code, JAM_NONE);
    endtask

    // Media in the path at wake is a residual jam, not a homing run
    task automatic t_residual();
        @(posedge clk);
        sens <= 1'h1;
        wake <= 1'h1;
        @(posedge clk);
        wake <= 1'h0;
        wait_bit(3, 1'h1, n);
        chk("residual code", code, JAM_RESIDUAL);
        chk("residual idle", {sol, clu, mot}, 3'h0);
        eng_u.send_stop();
        wait_bit(3, 1'h0, n);
        chk("reports", notes, 8'h02);
        @(posedge clk);
        sens <= 1'h0;
    endtask

    // Feed-stop ends homing and a retry wait; pickup while busy is dropped
    task automatic t_stops();
        @(posedge clk);
        door <= 1'h1;
        @(posedge clk);
        door <= 1'h0;
        wait_bit(0, 1'h1, n);
        eng_u.send_pickup();
        @(negedge clk);
        chk("pickup refused", {sol, clu, mot}, 3'h1);
        eng_u.send_stop();
        wait_bit(4, 1'h0, n);
        @(negedge clk);
        chk("homing stopped", {sol, mot, busy}, 3'h0);
        eng_u.send_pickup();
        wait_bit(2, 1'h1, n);
        wait_bit(0, 1'h0, n);
        wait_bit(0, 1'h1, n);
        eng_u.send_stop();
        wait_bit(4, 1'h0, n);
        chk("refire cancelled", {jam, sol, mot}, 3'h0);
        @(posedge clk);
        sens <= 1'h1;
        door <= 1'h1;
        @(posedge clk);
        door <= 1'h0;
        wait_bit(3, 1'h1, n);
        chk("door residual", {code, mot}, 3'h4);
        eng_u.send_stop();
        wait_bit(3, 1'h0, n);
        chk("reports", notes, 8'h03);
        @(posedge clk);
        sens <= 1'h0;
    endtask

    // Watchdog sized well past the few hundred cycles the tests need
    initial
    begin
        #100000;
        err_total++;
        complete_run();
    end

    // Main sequence: reset for 8 cycles, then the scenarios in turn
    initial
    begin
        rstn = 1'h0;
        {door, wake, tray, sens, home, btw} = 6'h00;
        repeat (8) @(posedge clk);
        chk("reset drives", drv, 5'h00);
        rstn <= 1'h1;
        t_home();
        t_feed();
        t_retry_jam();
        t_residual();
        t_stops();
        complete_run();
    end
endmodule // tray_pickup_sequencer_bench
